/* core/ssc_consts.vh */
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// ****************************************
// Register indices
// ****************************************
`define SSC_REG_SEQ 4'h0
`define SSC_REG_COL_START 4'h1
`define SSC_REG_ROW_START 4'h2
`define SSC_REG_KERNELS 4'h3
`define SSC_REG_RST_LEN 4'h4
`define SSC_REG_DS_POS 4'h5
`define SSC_REG_TS_POS 4'h6
`define SSC_REG_FT_POS 4'h7
`define SSC_REG_CAL_CODE 4'h8
`define SSC_REG_BLACK_CODE 4'h9
`define SSC_REG_OFS_CODE 4'ha
`define SSC_REG_ADC_SEL 4'hb
`define SSC_REG_AMP 4'hc
`define SSC_REG_TRIM_LO 4'hd
`define SSC_REG_TRIM_MID 4'he
`define SSC_REG_TRIM_HI 4'hf

// ****************************************
// Sequencer control word fields
// ****************************************
`define SSC_BIT_MASTER 0
`define SSC_BIT_ROW_SKIP 1
`define SSC_GRAN_LSB 2
`define SSC_GRAN_MSB 3
`define SSC_BIT_ANA_OUT 4
`define SSC_BIT_CAL_LINE 5
`define SSC_BIT_DS_ON 6
`define SSC_BIT_TS_ON 7
`define SSC_BIT_REV_X 8
`define SSC_BIT_REV_Y 9
`define SSC_BIT_NDR 10

// ****************************************
// Reset values
// ****************************************
`define SSC_RST_SEQ 11'h029
`define SSC_RST_COL_START 8'h00
`define SSC_RST_ROW_START 9'h000
`define SSC_RST_KERNELS 8'ha0
`define SSC_RST_RST_LEN 12'h002
`define SSC_RST_DS_POS 12'h000
`define SSC_RST_TS_POS 12'h000
`define SSC_RST_FT_POS 12'h1e1
`define SSC_RST_CAL_CODE 8'h4a
`define SSC_RST_BLACK_CODE 8'h6b
`define SSC_RST_OFS_CODE 8'h55
`define SSC_RST_ADC_SEL 12'h0f0
`define SSC_RST_AMP 12'hfb0
`define SSC_RST_TRIM_LO 12'hadf
`define SSC_RST_TRIM_MID 12'h6db
`define SSC_RST_TRIM_HI 9'h0db

// ****************************************
// Timing
// ****************************************
`define SSC_DIV_LAST 2'h3
`define SSC_ROW_OVERHEAD 9'h004
`define SSC_ROWS 9'h1e0
`define SSC_ROW_STEP 9'h001
`define SSC_ROW_STEP_SKIP 9'h002
`define SSC_KERNEL_STEP 8'h01
`define SSC_LINE_STEP 12'h001

`endif

/* core/ssc_sequencer.v */
// Overview of operation
// - Whole array resets together, then all pixels sample at once into storage.
// - After the global sample the stored array is read out line by line.
// - Next integration runs overlapped with readout or strictly after it.
// - Non-destructive mode never pulses array reset and reads the same pixels repeatedly.
// - Sequencer runs on the converter rate, input clock divided by four.
// - Register 0 is the 11-bit control word; master bit, reset 0x029.
// - Row-skip bit set reads every other row, clear reads all rows.
// - Control word holds granularity, line calibration and analog output enable.
// - Dual and triple slope enable bits gate their extra reset pulses.
// - Two bits reverse horizontal and vertical readout order when set.
// - Top control bit enables non-destructive readout.
// - Register 1 is the 8-bit column start pointer, reset zero.
// - Register 2 is the 9-bit row start pointer, reset zero.
// - Register 3 counts four-pixel kernels per line, reset 0xa0.
// - Register 4 is the 12-bit reset pulse length in lines, reset 2.
// - Registers 5 and 6 place dual and triple slope pulses, reset zero.
// - Register 7 places the frame transfer line, reset 0x1e1.
// - Registers 8 to 10 are reference DAC codes 0x4a, 0x6b, 0x55.
// - Register 11 holds test path, normal path and bypass fields, reset 0x0f0.
// - Register 12 holds amplifier gain and enables, reset 0xfb0.
// - Registers 13 to 15 form the 33-bit converter calibration word.
// - In slave mode three pins time integration; readout stays internal.
`timescale 1ns/1ps
`include "ssc_consts.vh"

module ssc_sequencer (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	input wire seq_resetn,
	// Register port
	input wire reg_write,
	input wire [3:0] reg_addr,
	input wire [11:0] reg_wdata,
	output reg [11:0] reg_rdata,
	// Mode strap
	input wire overlap_mode,
	// Integration control pins
	input wire int_time_1_in,
	input wire int_time_2_in,
	input wire int_time_3_in,
	output reg int_time_1_out,
	output reg int_time_2_out,
	output reg int_time_3_out,
	output wire int_time_oe_n,
	// Pixel array control
	output reg array_reset,
	output reg dual_slope_reset,
	output reg triple_slope_reset,
	output reg pixel_sample,
	output reg [8:0] row_addr,
	output reg [7:0] col_addr,
	output reg frame_valid,
	output reg line_valid,
	// Sequencer tick and analog settings
	output reg seq_tick,
	output wire [1:0] granularity,
	output wire analog_out_on,
	output wire line_calibration,
	output wire [7:0] calibration_level_code,
	output wire [7:0] black_level_code,
	output wire [7:0] offset_level_code,
	output wire [11:0] converter_input_select,
	output wire [11:0] amplifier_setting,
	output wire [32:0] converter_trim
);

	localparam TL_IDLE = 2'h0;
	localparam TL_RUN = 2'h1;
	localparam TL_WAIT = 2'h2;
	localparam RO_IDLE = 2'h0;
	localparam RO_LINE = 2'h1;
	localparam RO_FOT = 2'h2;

	// ****************************************
	// Registers
	// ****************************************
	reg [10:0] sequencer_control;
	reg [7:0] column_start_pointer;
	reg [8:0] row_start_pointer;
	reg [7:0] kernel_count;
	reg [11:0] reset_pulse_length;
	reg [11:0] dual_slope_position;
	reg [11:0] triple_slope_position;
	reg [11:0] transfer_position;
	reg [7:0] calibration_level;
	reg [7:0] black_level;
	reg [7:0] offset_level;
	reg [11:0] input_select;
	reg [11:0] amp_setting;
	reg [11:0] converter_trim_low;
	reg [11:0] converter_trim_mid;
	reg [8:0] converter_trim_high;

	wire master_mode = sequencer_control[`SSC_BIT_MASTER];
	wire row_skip = sequencer_control[`SSC_BIT_ROW_SKIP];
	wire dual_slope_on = sequencer_control[`SSC_BIT_DS_ON];
	wire triple_slope_on = sequencer_control[`SSC_BIT_TS_ON];
	wire reverse_x = sequencer_control[`SSC_BIT_REV_X];
	wire reverse_y = sequencer_control[`SSC_BIT_REV_Y];
	wire ndr_on = sequencer_control[`SSC_BIT_NDR];

	assign granularity = sequencer_control[`SSC_GRAN_MSB:`SSC_GRAN_LSB];
	assign analog_out_on = sequencer_control[`SSC_BIT_ANA_OUT];
	assign line_calibration = sequencer_control[`SSC_BIT_CAL_LINE];
	assign calibration_level_code = calibration_level;
	assign black_level_code = black_level;
	assign offset_level_code = offset_level;
	assign converter_input_select = input_select;
	assign amplifier_setting = amp_setting;
	assign converter_trim = {converter_trim_high, converter_trim_mid, converter_trim_low};

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sequencer_control <= `SSC_RST_SEQ;
			column_start_pointer <= `SSC_RST_COL_START;
			row_start_pointer <= `SSC_RST_ROW_START;
			kernel_count <= `SSC_RST_KERNELS;
			reset_pulse_length <= `SSC_RST_RST_LEN;
			dual_slope_position <= `SSC_RST_DS_POS;
			triple_slope_position <= `SSC_RST_TS_POS;
			transfer_position <= `SSC_RST_FT_POS;
			calibration_level <= `SSC_RST_CAL_CODE;
			black_level <= `SSC_RST_BLACK_CODE;
			offset_level <= `SSC_RST_OFS_CODE;
			input_select <= `SSC_RST_ADC_SEL;
			amp_setting <= `SSC_RST_AMP;
			converter_trim_low <= `SSC_RST_TRIM_LO;
			converter_trim_mid <= `SSC_RST_TRIM_MID;
			converter_trim_high <= `SSC_RST_TRIM_HI;
		end else if (reg_write) begin
			case (reg_addr)
				`SSC_REG_SEQ: sequencer_control <= reg_wdata[10:0];
				`SSC_REG_COL_START: column_start_pointer <= reg_wdata[7:0];
				`SSC_REG_ROW_START: row_start_pointer <= reg_wdata[8:0];
				`SSC_REG_KERNELS: kernel_count <= reg_wdata[7:0];
				`SSC_REG_RST_LEN: reset_pulse_length <= reg_wdata;
				`SSC_REG_DS_POS: dual_slope_position <= reg_wdata;
				`SSC_REG_TS_POS: triple_slope_position <= reg_wdata;
				`SSC_REG_FT_POS: transfer_position <= reg_wdata;
				`SSC_REG_CAL_CODE: calibration_level <= reg_wdata[7:0];
				`SSC_REG_BLACK_CODE: black_level <= reg_wdata[7:0];
				`SSC_REG_OFS_CODE: offset_level <= reg_wdata[7:0];
				`SSC_REG_ADC_SEL: input_select <= reg_wdata;
				`SSC_REG_AMP: amp_setting <= reg_wdata;
				`SSC_REG_TRIM_LO: converter_trim_low <= reg_wdata;
				`SSC_REG_TRIM_MID: converter_trim_mid <= reg_wdata;
				`SSC_REG_TRIM_HI: converter_trim_high <= reg_wdata[8:0];
				default: sequencer_control <= sequencer_control;
			endcase
		end
	end

	// Readback of the addressed register, narrow ones zero-extended
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 12'h000;
		end else begin
			case (reg_addr)
				`SSC_REG_SEQ: reg_rdata <= {1'b0, sequencer_control};
				`SSC_REG_COL_START: reg_rdata <= {4'h0, column_start_pointer};
				`SSC_REG_ROW_START: reg_rdata <= {3'h0, row_start_pointer};
				`SSC_REG_KERNELS: reg_rdata <= {4'h0, kernel_count};
				`SSC_REG_RST_LEN: reg_rdata <= reset_pulse_length;
				`SSC_REG_DS_POS: reg_rdata <= dual_slope_position;
				`SSC_REG_TS_POS: reg_rdata <= triple_slope_position;
				`SSC_REG_FT_POS: reg_rdata <= transfer_position;
				`SSC_REG_CAL_CODE: reg_rdata <= {4'h0, calibration_level};
				`SSC_REG_BLACK_CODE: reg_rdata <= {4'h0, black_level};
				`SSC_REG_OFS_CODE: reg_rdata <= {4'h0, offset_level};
				`SSC_REG_ADC_SEL: reg_rdata <= input_select;
				`SSC_REG_AMP: reg_rdata <= amp_setting;
				`SSC_REG_TRIM_LO: reg_rdata <= converter_trim_low;
				`SSC_REG_TRIM_MID: reg_rdata <= converter_trim_mid;
				default: reg_rdata <= {3'h0, converter_trim_high};
			endcase
		end
	end

	// ****************************************
	// Sequencer rate and line timing
	// ****************************************
	function at_line;
		input [11:0] pos;
		input [11:0] line;
		begin
			at_line = (pos != 12'h000) && (line == pos - `SSC_LINE_STEP);
		end
	endfunction

	reg [1:0] div_cnt;
	reg [8:0] line_phase;
	wire [8:0] line_len = {1'b0, kernel_count} + `SSC_ROW_OVERHEAD;
	wire line_end = seq_tick && (line_phase == line_len - `SSC_ROW_STEP);

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 2'h0;
			seq_tick <= 1'b0;
			line_phase <= 9'h000;
		end else if (!seq_resetn) begin
			div_cnt <= 2'h0;
			seq_tick <= 1'b0;
			line_phase <= 9'h000;
		end else begin
			div_cnt <= div_cnt + 2'h1;
			seq_tick <= (div_cnt == `SSC_DIV_LAST);
			if (line_end)
				line_phase <= 9'h000;
			else if (seq_tick)
				line_phase <= line_phase + `SSC_ROW_STEP;
		end
	end

	// ****************************************
	// Integration timeline
	// ****************************************
	reg [1:0] tl_state;
	reg [11:0] tl_line;
	reg [1:0] ro_state;
	reg int1_q, int2_q, int3_q;
	wire ro_idle = (ro_state == RO_IDLE);
	wire m_transfer = master_mode && (tl_state == TL_RUN) && line_end && ro_idle &&
		at_line(transfer_position, tl_line);
	wire s_transfer = !master_mode && int1_q && !int_time_1_in && ro_idle;
	wire transfer = m_transfer || s_transfer;

	assign int_time_oe_n = !master_mode;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tl_state <= TL_IDLE;
			tl_line <= 12'h000;
			int1_q <= 1'b0;
			int2_q <= 1'b0;
			int3_q <= 1'b0;
			array_reset <= 1'b0;
			dual_slope_reset <= 1'b0;
			triple_slope_reset <= 1'b0;
			pixel_sample <= 1'b0;
			int_time_1_out <= 1'b0;
			int_time_2_out <= 1'b0;
			int_time_3_out <= 1'b0;
		end else if (!seq_resetn) begin
			tl_state <= TL_IDLE;
			tl_line <= 12'h000;
			array_reset <= 1'b0;
			dual_slope_reset <= 1'b0;
			triple_slope_reset <= 1'b0;
			pixel_sample <= 1'b0;
			int_time_1_out <= 1'b0;
			int_time_2_out <= 1'b0;
			int_time_3_out <= 1'b0;
		end else begin
			int1_q <= int_time_1_in;
			int2_q <= int_time_2_in;
			int3_q <= int_time_3_in;
			pixel_sample <= transfer;
			if (!master_mode) begin
				tl_state <= TL_IDLE;
				tl_line <= 12'h000;
				array_reset <= !int_time_1_in && !ndr_on;
				dual_slope_reset <= dual_slope_on && int_time_2_in && !int2_q;
				triple_slope_reset <= triple_slope_on && int_time_3_in && !int3_q;
				int_time_1_out <= 1'b0;
				int_time_2_out <= 1'b0;
				int_time_3_out <= 1'b0;
			end else begin
				case (tl_state)
					TL_IDLE: begin
						if (line_end) begin
							tl_state <= TL_RUN;
							tl_line <= 12'h000;
						end
					end
					TL_RUN: begin
						if (line_end) begin
							if (m_transfer) begin
								tl_line <= 12'h000;
								tl_state <= overlap_mode ? TL_RUN : TL_WAIT;
							end else if (!at_line(transfer_position, tl_line)) begin
								tl_line <= tl_line + `SSC_LINE_STEP;
							end
						end
					end
					TL_WAIT: begin
						if (ro_idle && line_end) begin
							tl_state <= TL_RUN;
							tl_line <= 12'h000;
						end
					end
					default: tl_state <= TL_IDLE;
				endcase
				// Whole array held in reset for the first reset_pulse_length - 1 lines of each frame, except in non-destructive mode
				array_reset <= (tl_state == TL_RUN) && !ndr_on &&
					(tl_line < reset_pulse_length - `SSC_LINE_STEP);
				dual_slope_reset <= (tl_state == TL_RUN) && dual_slope_on &&
					at_line(dual_slope_position, tl_line);
				triple_slope_reset <= (tl_state == TL_RUN) && triple_slope_on &&
					at_line(triple_slope_position, tl_line);
				int_time_1_out <= (tl_state == TL_RUN) &&
					(tl_line >= reset_pulse_length - `SSC_LINE_STEP);
				if (dual_slope_reset)
					int_time_2_out <= 1'b1;
				else if (transfer || tl_state != TL_RUN)
					int_time_2_out <= 1'b0;
				if (triple_slope_reset)
					int_time_3_out <= 1'b1;
				else if (transfer || tl_state != TL_RUN)
					int_time_3_out <= 1'b0;
			end
		end
	end

	// ****************************************
	// Readout
	// ****************************************
	reg [8:0] row_cnt;
	reg [7:0] kern_cnt;
	wire [8:0] row_step = row_skip ? `SSC_ROW_STEP_SKIP : `SSC_ROW_STEP;
	wire [9:0] row_next = {1'b0, row_cnt} + {1'b0, row_step};
	wire [8:0] row_last = `SSC_ROWS - `SSC_ROW_STEP;
	wire [7:0] col_last = column_start_pointer + kernel_count - `SSC_KERNEL_STEP;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ro_state <= RO_IDLE;
			row_cnt <= 9'h000;
			kern_cnt <= 8'h00;
			row_addr <= 9'h000;
			col_addr <= 8'h00;
			frame_valid <= 1'b0;
			line_valid <= 1'b0;
		end else if (!seq_resetn) begin
			ro_state <= RO_IDLE;
			row_cnt <= 9'h000;
			kern_cnt <= 8'h00;
			frame_valid <= 1'b0;
			line_valid <= 1'b0;
		end else begin
			case (ro_state)
				RO_IDLE: begin
					if (transfer) begin
						ro_state <= RO_FOT;
						row_cnt <= row_start_pointer;
					end
				end
				RO_FOT: begin
					if (line_end && frame_valid) begin
						ro_state <= RO_IDLE;
						frame_valid <= 1'b0;
					end else if (line_end) begin
						ro_state <= RO_LINE;
						frame_valid <= 1'b1;
					end
				end
				RO_LINE: begin
					if (line_end) begin
						if (row_next > {1'b0, row_last})
							ro_state <= RO_FOT;
						else
							row_cnt <= row_next[8:0];
					end
				end
				default: ro_state <= RO_IDLE;
			endcase
			if (ro_state == RO_LINE && seq_tick && line_phase < {1'b0, kernel_count}) begin
				line_valid <= 1'b1;
				kern_cnt <= kern_cnt + `SSC_KERNEL_STEP;
				col_addr <= reverse_x ? col_last - kern_cnt
					: column_start_pointer + kern_cnt;
				row_addr <= reverse_y ? row_last - row_cnt : row_cnt;
			end else if (seq_tick) begin
				line_valid <= 1'b0;
				if (line_phase >= {1'b0, kernel_count})
					kern_cnt <= 8'h00;
			end
		end
	end

endmodule // ssc_sequencer

/* dv/ssc_props.sv */
`timescale 1ns/1ps
module ssc_props (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	input wire seq_resetn,
	// Register port
	input wire reg_write,
	input wire [3:0] reg_addr,
	input wire [11:0] reg_wdata,
	// Sequencer outputs
	input wire seq_tick,
	input wire pixel_sample,
	input wire frame_valid,
	input wire line_valid,
	input wire dual_slope_reset,
	input wire [8:0] row_addr,
	input wire [7:0] col_addr,
	input wire [7:0] calibration_level_code,
	input wire [32:0] converter_trim
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_tick;
		disable iff (!resetn || !seq_resetn) seq_tick |=> !seq_tick [*3] ##1 seq_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing wrong");
	property p_sample_pulse; pixel_sample |=> !pixel_sample; endproperty
	a_sample_pulse: assert property (p_sample_pulse) else $error("sample too long");
	property p_sample_idle; pixel_sample |-> !frame_valid; endproperty
	a_sample_idle: assert property (p_sample_idle) else $error("sample during readout");
	property p_fv_after;
		disable iff (!resetn || !seq_resetn) pixel_sample |-> ##[1:1000] frame_valid;
	endproperty
	a_fv_after: assert property (p_fv_after) else $error("no readout after sample");
	property p_lv_in_fv; line_valid |-> frame_valid; endproperty
	a_lv_in_fv: assert property (p_lv_in_fv) else $error("line valid misplaced");
	property p_lv_hold;
		disable iff (!resetn || !seq_resetn)
			(line_valid && !seq_tick) |=> line_valid && $stable(col_addr);
	endproperty
	a_lv_hold: assert property (p_lv_hold) else $error("kernel slot cut short");
	property p_row_range; frame_valid |-> row_addr <= 9'h1df; endproperty
	a_row_range: assert property (p_row_range) else $error("row out of range");
	property p_col_step;
		disable iff (!resetn || !seq_resetn) (line_valid && $past(line_valid, 4)) |->
			(col_addr == $past(col_addr, 4) + 8'h01 || col_addr == $past(col_addr, 4) - 8'h01);
	endproperty
	a_col_step: assert property (p_col_step) else $error("kernel step wrong");
	property p_trim_hi;
		(reg_write && reg_addr == 4'hf) |=> converter_trim[32:24] == $past(reg_wdata[8:0]);
	endproperty
	a_trim_hi: assert property (p_trim_hi) else $error("trim high part wrong");
	property p_cal_code;
		(reg_write && reg_addr == 4'h8) |=> calibration_level_code == $past(reg_wdata[7:0]);
	endproperty
	a_cal_code: assert property (p_cal_code) else $error("level code wrong");
	c_sample: cover property (pixel_sample);
	c_frame: cover property ($rose(frame_valid));
	c_overlap: cover property (dual_slope_reset && frame_valid);
endmodule // ssc_props

/* dv/ssc_ctrl_model.sv */
`timescale 1ns/1ps
module ssc_ctrl_model (
	// Clock and status
	input wire sys_clk,
	input wire frame_valid,
	input wire [11:0] reg_rdata,
	// Register port
	output reg reg_write,
	output reg [3:0] reg_addr,
	output reg [11:0] reg_wdata,
	// Sequencer control
	output reg seq_resetn,
	output reg int_time_1_in,
	output reg int_time_2_in,
	output reg int_time_3_in
);
	// ****************************************
	// Controller actions
	// ****************************************
	initial begin
		reg_write = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 12'h000;
		seq_resetn = 1'b0;
		{int_time_3_in, int_time_2_in, int_time_1_in} = 3'h0;
	end
	task wr(input [3:0] a, input [11:0] d);
		begin
			@(posedge sys_clk);
			while (frame_valid !== 1'b0) @(posedge sys_clk);
			reg_write <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
			reg_write <= 1'b0;
			reg_wdata <= ~d;
		end
	endtask
	task rd(input [3:0] a, output [11:0] d);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			repeat (2) @(posedge sys_clk);
			#1 d = reg_rdata;
		end
	endtask
	// Mode and granularity are written only between these calls
	task seq_hold(input v);
		@(posedge sys_clk) seq_resetn <= v;
	endtask
	task pins(input [2:0] v);
		begin
			@(posedge sys_clk);
			{int_time_3_in, int_time_2_in, int_time_1_in} <= v;
			repeat (8) @(posedge sys_clk);
			#1;
		end
	endtask
endmodule // ssc_ctrl_model

/* dv/ssc_sequencer_bench.sv */
`timescale 1ns/1ps
module ssc_sequencer_bench;
	reg sys_clk, resetn, overlap_mode, mon_clr, fv_d;
	wire reg_write, seq_resetn, int_time_1_in, int_time_2_in, int_time_3_in, frame_valid;
	wire line_valid, pixel_sample, array_reset, dual_slope_reset, triple_slope_reset;
	wire int_time_oe_n, analog_out_on, line_calibration;
	wire seq_tick, int_time_1_out, int_time_2_out, int_time_3_out;
	wire [3:0] reg_addr;
	wire [11:0] reg_wdata, reg_rdata, amplifier_setting, converter_input_select;
	wire [8:0] row_addr;
	wire [7:0] col_addr, calibration_level_code, black_level_code, offset_level_code;
	wire [1:0] granularity;
	wire [32:0] converter_trim;
	integer n_errors, tests_run, n_fv, n_ps, n_ar, n_ds, n_ts, n_ov, n_lv;
	reg [8:0] row0;
	reg [7:0] col0, col1;
	reg [11:0] rst_tab [0:15];
	reg [11:0] msk [0:15];
	ssc_sequencer i_dut (.sys_clk, .resetn, .seq_resetn, .reg_write, .reg_addr, .reg_wdata,
		.reg_rdata, .overlap_mode, .int_time_1_in, .int_time_2_in, .int_time_3_in,
		.int_time_1_out, .int_time_2_out, .int_time_3_out, .int_time_oe_n, .array_reset,
		.dual_slope_reset, .triple_slope_reset, .pixel_sample, .row_addr, .col_addr,
		.frame_valid, .line_valid, .seq_tick, .granularity, .analog_out_on, .line_calibration,
		.calibration_level_code, .black_level_code, .offset_level_code,
		.converter_input_select, .amplifier_setting, .converter_trim);
	ssc_ctrl_model i_ctrl (.sys_clk, .frame_valid, .reg_rdata, .reg_write, .reg_addr,
		.reg_wdata, .seq_resetn, .int_time_1_in, .int_time_2_in, .int_time_3_in);
	// ****************************************
	// Clock, monitor and checking
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		fv_d <= frame_valid;
		if (mon_clr) begin
			{n_fv, n_ps, n_ar, n_ds, n_ts, n_ov, n_lv} <= 224'h0;
		end else if (n_fv == 0) begin
			if (fv_d && !frame_valid) n_fv <= 1;
			if (pixel_sample) n_ps <= n_ps + 1;
			if (array_reset) n_ar <= n_ar + 1;
			if (dual_slope_reset) n_ds <= n_ds + 1;
			if (triple_slope_reset) n_ts <= n_ts + 1;
			if (frame_valid && (array_reset || dual_slope_reset)) n_ov <= n_ov + 1;
			// Line valid spans a whole kernel slot; count each slot once, in its last cycle
			if (line_valid && seq_tick) begin
				if (n_lv == 0) {row0, col0} <= {row_addr, col_addr};
				if (n_lv == 1) col1 <= col_addr;
				n_lv <= n_lv + 1;
			end
		end
	end
	task check(input [63:0] seen, input [63:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	function [11:0] pat(input integer a);
		pat = 12'h9c6 ^ (a * 12'h111);
	endfunction
	task wait_frame;
		integer n;
		begin
			n = 0;
			while (n_fv == 0 && n < 30000) begin
				@(posedge sys_clk);
				n = n + 1;
			end
			check(n < 30000, 1'b1);
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		integer a;
		reg [11:0] d;
		begin
			for (a = 0; a < 16; a = a + 1) begin
				i_ctrl.rd(a[3:0], d);
				check(d, rst_tab[a]);
			end
			check({granularity, analog_out_on, line_calibration, int_time_oe_n}, 5'h12);
			check(converter_trim, 33'h0db6dbadf);
		end
	endtask
	task t_regs;
		integer a;
		reg [11:0] d;
		begin
			for (a = 1; a < 16; a = a + 1) i_ctrl.wr(a[3:0], pat(a));
			for (a = 1; a < 16; a = a + 1) begin
				i_ctrl.rd(a[3:0], d);
				check(d, pat(a) & msk[a]);
			end
			check(converter_trim, {pat(15) & 12'h1ff, pat(14), pat(13)} & 36'h1ffffffff);
			check({amplifier_setting, 4'h0, calibration_level_code}, {pat(12), pat(8) & 12'h0ff});
			check(black_level_code, pat(9) & 12'h0ff);
			check(offset_level_code, pat(10) & 12'h0ff);
			check(converter_input_select, pat(11));
		end
	endtask
	task t_frame(input [10:0] w, input [8:0] row, input [7:0] kc, input ov, input [8:0] er,
		input [7:0] ec0, input [7:0] ec1, input integer nl, input ds, input ar);
		reg [11:0] d;
		begin
			i_ctrl.seq_hold(1'b0);
			overlap_mode <= ov;
			mon_clr <= 1'b1;
			i_ctrl.wr(4'h0, {1'b0, w});
			i_ctrl.wr(4'h1, 12'h003);
			i_ctrl.wr(4'h2, {3'h0, row});
			i_ctrl.wr(4'h3, {4'h0, kc});
			i_ctrl.wr(4'h4, 12'h002);
			i_ctrl.wr(4'h5, 12'h003);
			i_ctrl.wr(4'h6, 12'h004);
			i_ctrl.wr(4'h7, 12'h006);
			mon_clr <= 1'b0;
			i_ctrl.seq_hold(1'b1);
			i_ctrl.rd(4'h0, d);
			check(d, {1'b0, w});
			wait_frame;
			check(row0, er);
			check({col0, col1}, {ec0, ec1});
			check(n_lv, nl);
			check(n_ps, 1);
			check({n_ds > 0, n_ar > 0, n_ov > 0}, {ds, ar, ov});
			check({granularity, analog_out_on, line_calibration}, {w[3:2], w[4], w[5]});
			check({int_time_3_out, int_time_2_out, int_time_1_out}, {3{ov}});
		end
	endtask
	task t_slave;
		begin
			i_ctrl.seq_hold(1'b0);
			mon_clr <= 1'b1;
			i_ctrl.wr(4'h0, 12'h0c0);
			i_ctrl.wr(4'h2, 12'h1de);
			i_ctrl.wr(4'h3, 12'h001);
			mon_clr <= 1'b0;
			i_ctrl.seq_hold(1'b1);
			i_ctrl.pins(3'b000);
			check({int_time_oe_n, array_reset}, 2'b11);
			i_ctrl.pins(3'b001);
			check(array_reset, 1'b0);
			i_ctrl.pins(3'b011);
			i_ctrl.pins(3'b111);
			i_ctrl.pins(3'b000);
			wait_frame;
			check({n_ds[7:0], n_ts[7:0], n_ps[7:0], n_lv[7:0]}, 32'h01010102);
			check({int_time_3_out, int_time_2_out, int_time_1_out}, 3'h0);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d, errors %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		resetn = 1'b0;
		overlap_mode = 1'b0;
		mon_clr = 1'b1;
		n_errors = 0;
		tests_run = 0;
		rst_tab = '{12'h029, 12'h000, 12'h000, 12'h0a0, 12'h002, 12'h000, 12'h000, 12'h1e1,
			12'h04a, 12'h06b, 12'h055, 12'h0f0, 12'hfb0, 12'hadf, 12'h6db, 12'h0db};
		msk = '{12'h7ff, 12'h0ff, 12'h1ff, 12'h0ff, 12'hfff, 12'hfff, 12'hfff, 12'hfff,
			12'h0ff, 12'h0ff, 12'h0ff, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'h1ff};
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset;
		t_regs;
		t_frame(11'h001, 9'h1dc, 8'h02, 1'b0, 9'h1dc, 8'h03, 8'h04, 8, 1'b0, 1'b1);
		t_frame(11'h3cd, 9'h1d6, 8'h02, 1'b1, 9'h009, 8'h04, 8'h03, 20, 1'b1, 1'b1);
		t_frame(11'h033, 9'h1d6, 8'h01, 1'b0, 9'h1d6, 8'h03, 8'h03, 5, 1'b0, 1'b1);
		t_frame(11'h401, 9'h1de, 8'h01, 1'b0, 9'h1de, 8'h03, 8'h03, 2, 1'b0, 1'b0);
		t_slave;
		report_and_stop;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors = n_errors + 1;
		report_and_stop;
	end
endmodule // ssc_sequencer_bench
bind ssc_sequencer ssc_props i_props (.sys_clk, .resetn, .seq_resetn, .reg_write, .reg_addr,
	.reg_wdata, .seq_tick, .pixel_sample, .frame_valid, .line_valid, .dual_slope_reset,
	.row_addr, .col_addr, .calibration_level_code, .converter_trim);
